/* File: core/tcr_pkg.sv */
// shared constants and carriers for the capture-restart timer
package tcr_pkg;

  localparam int          COUNT_W      = 16;
  localparam logic [15:0] RESTART_VAL  = 16'h0001;
  localparam logic [15:0] RELOAD_RST   = 16'hFFFF;
  localparam logic [15:0] START_RST    = 16'h0001;
  localparam logic [15:0] CAPTURE_RST  = 16'h0000;
  localparam logic [2:0]  PRESCALE_RST = 3'h0;

  // timer mode codes: lower field plus upper bit form the full mode
  localparam logic [2:0]  MODE_LO_CAPRST = 3'h7;
  localparam logic        MODE_HI_CAPRST = 1'h0;

  // interrupt source selection field
  localparam logic [1:0]  IRQ_SRC_BOTH    = 2'h0;
  localparam logic [1:0]  IRQ_SRC_CAPTURE = 2'h2;
  localparam logic [1:0]  IRQ_SRC_RELOAD  = 2'h3;

  typedef struct packed {
    logic        enable;
    logic [2:0]  mode_lo;
    logic        mode_upper_bit;
    logic        input_edge_polarity;
    logic [2:0]  prescale;
    logic [1:0]  irq_source_select;
  } tcr_cfg_s;

  typedef struct packed {
    logic [15:0] start_count;
    logic [15:0] reload_value;
  } tcr_vals_s;

endpackage

/* File: core/tcr_timer.sv */
// 16-bit timer, capture-restart mode, with control bits as plain ports
`timescale 1ns/10ps
`default_nettype none
module tcr_timer
  import tcr_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // configuration
  input  wire tcr_cfg_s             cfg,
  input  wire tcr_vals_s            vals,
  // external timer input
  input  wire logic                 timer_in,
  // status
  output logic [COUNT_W-1:0]        count,
  output logic [COUNT_W-1:0]        capture_value,
  output logic                      capture_cause_flag,
  output logic                      timer_irq
);

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic mode_ok;
  assign mode_ok = (cfg.mode_lo == MODE_LO_CAPRST) && (cfg.mode_upper_bit == MODE_HI_CAPRST);

  logic running;
  assign running = cfg.enable && mode_ok;

  a_mode_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    !mode_ok |=> !timer_irq && $stable(capture_value) && $stable(capture_cause_flag))
    else $error("events outside capture-restart mode");

  logic in_meta;
  logic in_sync;
  logic in_prev;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end
    else
    begin
      in_meta <= timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  logic edge_hit;
  assign edge_hit = cfg.input_edge_polarity ? (!in_sync && in_prev) : (in_sync && !in_prev);

  a_edge_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
    edge_hit |-> in_sync != cfg.input_edge_polarity)
    else $error("capture on wrong edge");

  logic [7:0] pre_cnt;
  logic [7:0] pre_max;
  logic       tick;
  assign pre_max = 8'((9'h001 << cfg.prescale) - 9'h001);
  assign tick    = running && (pre_cnt >= pre_max);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt <= 8'h00;
    else if (!running || tick)
      pre_cnt <= 8'h00;
    else
      pre_cnt <= pre_cnt + 8'h01;
  end

  logic capture_ev;
  logic reload_ev;
  assign capture_ev = running && edge_hit;
  assign reload_ev  = running && !edge_hit && tick && (count == vals.reload_value);

  a_edge_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture_ev |=> !edge_hit)
    else $error("double capture on one edge");

  // disabled timer holds the loaded start value
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= START_RST;
    else if (!running)
      count <= vals.start_count;
    else if (capture_ev)
      count <= RESTART_VAL;
    else if (reload_ev)
      count <= RESTART_VAL;
    else if (tick)
      count <= count + 16'h0001;
  end

  sequence s_capture_taken;
    capture_ev;
  endsequence
  sequence s_capture_restarted;
    (count == RESTART_VAL) && capture_cause_flag;
  endsequence
  a_capture_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_capture_taken |=> s_capture_restarted)
    else $error("capture did not restart count");
  sequence s_reload_taken;
    reload_ev;
  endsequence
  sequence s_reload_restarted;
    (count == RESTART_VAL) && !capture_cause_flag;
  endsequence
  a_reload_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_reload_taken |=> s_reload_restarted)
    else $error("reload did not restart count");
  a_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && !tick && !capture_ev) |=> $stable(count))
    else $error("count moved without prescale tick");
  a_start_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!running ##1 !running) |-> count == $past(vals.start_count))
    else $error("start value not loaded while disabled");

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      capture_value <= CAPTURE_RST;
    else if (capture_ev)
      capture_value <= count;
  end

  a_capture_value: assert property (@(posedge core_clk) disable iff (!rst_n)
    capture_ev |=> capture_value == $past(count))
    else $error("capture value mismatch");

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      capture_cause_flag <= 1'b0;
    else if (capture_ev)
      capture_cause_flag <= 1'b1;
    else if (reload_ev)
      capture_cause_flag <= 1'b0;
  end

  a_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(capture_cause_flag) |-> $past(capture_ev))
    else $error("cause flag set without capture");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reload_ev && !capture_ev) |=> !capture_cause_flag)
    else $error("cause flag not cleared on reload");

  logic next_irq;
  always_comb
  begin
    case (cfg.irq_source_select)
      IRQ_SRC_CAPTURE: next_irq = capture_ev;
      IRQ_SRC_RELOAD:  next_irq = reload_ev;
      default:         next_irq = capture_ev || reload_ev;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_irq <= 1'b0;
    else
      timer_irq <= next_irq;
  end

  a_irq_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
    timer_irq |-> ($past(cfg.irq_source_select) == IRQ_SRC_RELOAD ? $past(reload_ev)
      : $past(cfg.irq_source_select) == IRQ_SRC_CAPTURE ? $past(capture_ev)
      : $past(capture_ev || reload_ev)))
    else $error("interrupt from deselected source");
  a_irq_both: assert property (@(posedge core_clk) disable iff (!rst_n)
    (capture_ev && cfg.irq_source_select == IRQ_SRC_BOTH) |=> timer_irq)
    else $error("missing capture interrupt");

endmodule
`default_nettype wire

/* File: bench/tcr_pin_src.sv */
// external source model driving the timer input pin
`timescale 1ns/10ps
`default_nettype none
module tcr_pin_src
(
  // request and active edge
  input  wire logic edge_req,
  input  wire logic falling,
  // pin
  output wire logic timer_in
);
  // pin reaches timer
  // idle level opposite the active edge, so one request is one transition
  assign timer_in = edge_req ^ falling;
endmodule
`default_nettype wire

/* File: bench/tcr_timer_bench.sv */
// self-checking bench for the capture-restart timer
`timescale 1ns/10ps
`default_nettype none
module tcr_timer_bench;
  import tcr_pkg::*;
  logic        core_clk  = 1'b0;
  logic        nrst      = 1'b0;
  tcr_cfg_s    cfg       = '0;
  tcr_vals_s   vals      = '{16'h0001, 16'h0008};
  logic        edge_req  = 1'b0;
  wire logic   timer_in;
  logic [15:0] count;
  logic [15:0] capture_value;
  logic        capture_cause_flag;
  logic        timer_irq;
  int          errors    = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          n;

  tcr_timer uut (.core_clk(core_clk), .nrst(nrst), .cfg(cfg), .vals(vals),
    .timer_in(timer_in), .count(count), .capture_value(capture_value),
    .capture_cause_flag(capture_cause_flag), .timer_irq(timer_irq));
  tcr_pin_src src (.edge_req(edge_req), .falling(cfg.input_edge_polarity),
    .timer_in(timer_in));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // far beyond the longest expected run
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // disabled while programming, then enabled
  task automatic set_cfg(input logic hi, input logic pol, input logic [2:0] ps,
                         input logic [1:0] sel, input logic [15:0] rl,
                         input logic [15:0] st);
    @(posedge core_clk);
    cfg  <= '{1'b0, MODE_LO_CAPRST, hi, pol, ps, sel};
    vals <= '{st, rl};
    @(posedge core_clk);
    cfg.enable <= 1'b1;
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end while (timer_irq !== 1'b1 && n < lim);
  endtask

  task automatic quiet(input int lim);
    wait_irq(lim);
    chk(16'(timer_irq), 16'h0000);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    set_cfg(MODE_HI_CAPRST, 1'b0, 3'h0, IRQ_SRC_BOTH, 16'h0008, START_RST);
    wait_irq(40);
    chk(16'(n), 16'h0008);
    wait_irq(40);
    chk(16'(n), 16'h0008);
    chk(count, RESTART_VAL);
    chk(16'(capture_cause_flag), 16'h0000);
    $display("test reload done");
    // start above restart value shortens only the first period
    set_cfg(MODE_HI_CAPRST, 1'b0, 3'h0, IRQ_SRC_BOTH, 16'h0008, 16'h0005);
    wait_irq(40);
    chk(16'(n), 16'h0004);
    chk(count, RESTART_VAL);
    $display("test start value done");
    for (int p = 0; p < 2; p++)
    begin
      set_cfg(MODE_HI_CAPRST, p[0], 3'h0, IRQ_SRC_BOTH, 16'h0100, START_RST);
      wait_irq(300);
      repeat (5) @(posedge core_clk);
      edge_req <= 1'b1;
      wait_irq(20);
      chk(16'(n), 16'h0003);
      chk(capture_value, 16'h0008);
      chk(count, RESTART_VAL);
      chk(16'(capture_cause_flag), 16'h0001);
      quiet(12);
      edge_req <= 1'b0;
      quiet(12);
      $display("test capture polarity %0d done", p);
    end
    // slow prescale doubles the reload period
    set_cfg(MODE_HI_CAPRST, 1'b0, 3'h1, IRQ_SRC_BOTH, 16'h0008, START_RST);
    wait_irq(40);
    wait_irq(40);
    chk(16'(n), 16'h0010);
    $display("test prescale done");
    set_cfg(MODE_HI_CAPRST, 1'b0, 3'h0, IRQ_SRC_CAPTURE, 16'h0008, START_RST);
    quiet(30);
    edge_req <= 1'b1;
    wait_irq(20);
    chk(16'(timer_irq), 16'h0001);
    edge_req <= 1'b0;
    set_cfg(MODE_HI_CAPRST, 1'b0, 3'h0, IRQ_SRC_RELOAD, 16'h0100, START_RST);
    repeat (5) @(posedge core_clk);
    edge_req <= 1'b1;
    quiet(20);
    edge_req <= 1'b0;
    $display("test irq source done");
    set_cfg(~MODE_HI_CAPRST, 1'b0, 3'h0, IRQ_SRC_BOTH, 16'h0008, 16'h0005);
    quiet(30);
    chk(count, 16'h0005);
    $display("test mode select done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
